// ==== src/echo_pin_map.svh ====
// offsets, field positions, reset values and timing counts of the echo canceller pin interface
`ifndef ECHO_PIN_MAP_SVH
`define ECHO_PIN_MAP_SVH

// host port, channel and stream widths
`define ADDR_W 11
`define DATA_W 8
`define NUM_CH 4
`define STREAM_BITS 32
`define FRAME_WORD_W 64

// register offsets on the host port
`define REG_MAIN_CTRL 11'h000
`define REG_STATUS 11'h001
`define REG_INT_FIFO 11'h002

// field positions and reset values
`define MAIN_CTRL_RESET 8'h00
`define MAIN_CTRL_ODE_BIT 6
`define INT_VALID_BIT 7

// initialisation time after reset release
`define SYS_CLK_PERIOD_NS 8
`define INIT_TIME_NS 1000
`define INIT_CYCLES ((`INIT_TIME_NS + `SYS_CLK_PERIOD_NS - 1) / `SYS_CLK_PERIOD_NS)
`define INIT_CNT_W 8

// serial link timing
`define LINK_CLK_KHZ 4096
`define FRAME_RATE_KHZ 8
`define HALF_BITS_PER_FRAME (`LINK_CLK_KHZ / `FRAME_RATE_KHZ)
`define HALF_CNT_W 9
`define FP_IDLE_MIN 8
`define FP_RUN_W 4

// test access port
`define TAP_IR_W 4
`define TAP_IR_BYPASS 4'hf
`define TAP_IR_CAPTURE 4'h1

`endif

// ==== src/echo_pin_pkg.sv ====
// types shared by the echo canceller pin interface modules
package echo_pin_pkg;
  `include "echo_pin_map.svh"

  typedef enum logic [1:0] {HS_IDLE, HS_DRIVE, HS_ACK} host_state_type;

  typedef enum logic [3:0] {TAP_RESET, TAP_IDLE, TAP_SEL_DR, TAP_CAP_DR, TAP_SHIFT_DR, TAP_EXIT1_DR,
    TAP_PAUSE_DR, TAP_EXIT2_DR, TAP_UPD_DR, TAP_SEL_IR, TAP_CAP_IR, TAP_SHIFT_IR, TAP_EXIT1_IR,
    TAP_PAUSE_IR, TAP_EXIT2_IR, TAP_UPD_IR} tap_state_type;

  typedef struct packed {
    logic cs_n_s1, cs_n_s2, ds_n_s1, ds_n_s2, rw_s1, rw_s2;
    logic [`ADDR_W-1:0] addr_s1, addr_s2;
    logic [`DATA_W-1:0] data_s1, data_s2;
    logic ode_s1, ode_s2, fsel_s1, fsel_s2, gci_s1, gci_s2, rx_tog_s1, rx_tog_s2, rx_tog_seen;
    host_state_type hs;
    logic [`DATA_W-1:0] data_out;
    logic data_oe, ack_oe, irq_oe;
    logic [`NUM_CH-1:0] pending;
    logic [`DATA_W-1:0] main_ctrl;
    logic standby;
    logic [`INIT_CNT_W-1:0] init_cnt;
    logic drive_en, link_rst_n, tx_tog, rx_valid;
    logic [`FRAME_WORD_W-1:0] tx_word, rx_sample;
  } host_regs_type;

  typedef struct packed {
    logic rst_s1, rst_s2, en_s1, en_s2, tx_tog_s1, tx_tog_s2, tx_seen;
    logic fp_q, idle_lvl, gci, locked;
    logic [`FP_RUN_W-1:0] fp_run;
    logic [`HALF_CNT_W-1:0] half;
    logic [`STREAM_BITS-1:0] rx_s, rx_r, tx_s, tx_r;
    logic [`FRAME_WORD_W-1:0] rx_word;
    logic rx_tog, send_out, send_oe, recv_out, recv_oe;
  } link_regs_type;

  typedef struct packed {
    tap_state_type tap;
    logic [`TAP_IR_W-1:0] ir, ir_shift;
    logic bypass;
  } tap_regs_type;
endpackage

// ==== src/tdm_link_if.sv ====
// signals between the host-side controller and the serial link port
`timescale 1ns/1ns
interface tdm_link_if;
  logic [63:0] rx_word;
  logic rx_tog;
  logic [63:0] tx_word;
  logic tx_tog;
  logic drive_en;
  logic gci;
  logic link_resetn;

  modport ctrl (output tx_word, tx_tog, drive_en, link_resetn, input rx_word, rx_tog, gci);
  modport link (input tx_word, tx_tog, drive_en, link_resetn, output rx_word, rx_tog, gci);
endinterface

// ==== src/tdm_serial_port.sv ====
// serial pcm port on the link clock: frame lock, shifting and crossing handshakes
`timescale 1ns/1ns
`include "echo_pin_map.svh"
module tdm_serial_port
  import echo_pin_pkg::*;
(
  // link clock
  input wire logic serial_bit_clock_i,
  // frame and data pins
  input wire logic frame_pulse_in_i,
  input wire logic receive_pcm_in_i,
  input wire logic send_pcm_in_i,
  output logic send_pcm_out_o,
  output logic send_pcm_out_oe_o,
  output logic receive_pcm_out_o,
  output logic receive_pcm_out_oe_o,
  // controller side
  tdm_link_if.link lb
);
  import echo_pin_pkg::*;

  link_regs_type st_reg;
  link_regs_type st_next;
  logic [7:0] bit_idx;
  logic frame_edge;
  logic last_sample;

  // ****************************************************************
  // frame lock, bit shifting and handshakes
  // ****************************************************************
  always_comb
  begin
    st_next = st_reg;
    bit_idx = 8'(st_reg.half[`HALF_CNT_W-1:1]);
    // levels from the other domain pass two flops here
    st_next.rst_s1 = lb.link_resetn;
    st_next.rst_s2 = st_reg.rst_s1;
    st_next.en_s1 = lb.drive_en;
    st_next.en_s2 = st_reg.en_s1;
    st_next.tx_tog_s1 = lb.tx_tog;
    st_next.tx_tog_s2 = st_reg.tx_tog_s1;
    st_next.fp_q = frame_pulse_in_i;
    st_next.half = st_reg.half + 9'h001; // wraps once per frame
    // a pulse is a change after a long quiet run; its polarity names the format
    frame_edge = (frame_pulse_in_i != st_reg.fp_q) && (st_reg.fp_run >= 4'(`FP_IDLE_MIN - 1));
    if (frame_pulse_in_i == st_reg.fp_q)
      st_next.fp_run = (st_reg.fp_run == '1) ? st_reg.fp_run : st_reg.fp_run + 4'h1;
    else
      st_next.fp_run = '0;
    // two half-bits per bit: 2.048 Mbps on a 4.096 MHz clock, sampled on the second
    last_sample = st_reg.locked && (bit_idx == 8'(`STREAM_BITS - 1)) && st_reg.half[0];
    if (st_reg.locked && (bit_idx < 8'(`STREAM_BITS)) && st_reg.half[0])
    begin
      st_next.rx_s = {st_reg.rx_s[`STREAM_BITS-2:0], receive_pcm_in_i};
      st_next.rx_r = {st_reg.rx_r[`STREAM_BITS-2:0], send_pcm_in_i};
      st_next.tx_s = {st_reg.tx_s[`STREAM_BITS-2:0], 1'b0};
      st_next.tx_r = {st_reg.tx_r[`STREAM_BITS-2:0], 1'b0};
    end
    // whole frame handed over by toggle; the word stays put for a frame
    if (last_sample)
    begin
      st_next.rx_word = {st_next.rx_s, st_next.rx_r};
      st_next.rx_tog = ~st_reg.rx_tog;
    end
    if (frame_edge)
    begin
      st_next.half = '0;
      st_next.locked = 1'b1;
      st_next.idle_lvl = st_reg.fp_q;
      st_next.gci = frame_pulse_in_i;
      if (st_reg.tx_tog_s2 != st_reg.tx_seen)
      begin
        st_next.tx_seen = st_reg.tx_tog_s2;
        st_next.tx_s = lb.tx_word[63:32];
        st_next.tx_r = lb.tx_word[31:0];
      end
    end
    // outputs drive only the four timeslots, and only when enabled
    st_next.send_out = st_next.tx_s[`STREAM_BITS-1];
    st_next.recv_out = st_next.tx_r[`STREAM_BITS-1];
    st_next.send_oe = st_reg.en_s2 && st_next.locked && (st_next.half[`HALF_CNT_W-1:1] < 8'(`STREAM_BITS));
    st_next.recv_oe = st_next.send_oe;
    if (!st_reg.rst_s2)
    begin
      st_next = '0;
      st_next.rst_s1 = lb.link_resetn;
      st_next.rst_s2 = st_reg.rst_s1;
    end
  end

  // the link clock may stop outside frames; state simply holds
  always_ff @(posedge serial_bit_clock_i)
  begin
    st_reg <= st_next;
  end

  // outputs and handshake words straight from flops
  assign send_pcm_out_o = st_reg.send_out;
  assign send_pcm_out_oe_o = st_reg.send_oe;
  assign receive_pcm_out_o = st_reg.recv_out;
  assign receive_pcm_out_oe_o = st_reg.recv_oe;
  assign lb.rx_word = st_reg.rx_word;
  assign lb.rx_tog = st_reg.rx_tog;
  assign lb.gci = st_reg.gci;

  // ****************************************************************
  // checks on the link clock
  // ****************************************************************
  property p_hiz_when_off;
    @(posedge serial_bit_clock_i) disable iff (!st_reg.rst_s2)
    !st_reg.en_s2 |=> !send_pcm_out_oe_o && !receive_pcm_out_oe_o;
  endproperty
  a_hiz_when_off: assert property (p_hiz_when_off) else $error("pcm outputs driven while disabled");

  sequence s_quiet_then_edge;
    (st_reg.fp_run >= 4'(`FP_IDLE_MIN - 1)) && (frame_pulse_in_i != st_reg.fp_q);
  endsequence
  property p_frame_lock;
    @(posedge serial_bit_clock_i) disable iff (!st_reg.rst_s2)
    s_quiet_then_edge |=> (st_reg.half == '0) && st_reg.locked && (st_reg.gci == $past(frame_pulse_in_i));
  endproperty
  a_frame_lock: assert property (p_frame_lock) else $error("frame pulse not locked");

  property p_rx_handover;
    @(posedge serial_bit_clock_i) disable iff (!st_reg.rst_s2)
    last_sample |=> (st_reg.rx_tog != $past(st_reg.rx_tog)) && (st_reg.rx_word[32] == $past(receive_pcm_in_i));
  endproperty
  a_rx_handover: assert property (p_rx_handover) else $error("received frame not handed over");
endmodule

// ==== src/echo_canceller_pin_interface.sv ====
// host port, interrupt, reset, test port and serial link of the four-channel echo canceller
// Behaviour
// - interrupt pin low while any channel event pending
// - interrupt released after all fifo entries read
// - access only while select and strobe low
// - direction pin chooses drive or sample of data
// - acknowledge pulled low when transfer completes
// - eight-bit two-way data bus
// - pcm outputs enabled by pin and control bit
// - either enable low makes pcm outputs high impedance
// - two output streams, four channels, 2.048 Mbps
// - two input streams, four channels, 2.048 Mbps
// - frame format recognised and locked automatically
// - streams shifted on 4.096 MHz bit clock
// - master clock runs asynchronously to frame timing
// - test data out on falling edge, otherwise hiz
// - test reset forces tap reset asynchronously
// - reset low holds device in standby
// - after release, initialisation ends standby itself after 125 cycles
`timescale 1ns/1ns
`include "echo_pin_map.svh"
module echo_canceller_pin_interface
  import echo_pin_pkg::*;
(
  // system clock and reset
  input wire logic sys_clk_i,
  input wire logic resetn_i,
  // host port
  input wire logic chip_select_n_i,
  input wire logic data_strobe_n_i,
  input wire logic read_write_dir_i,
  input wire logic [10:0] host_address_bus_i,
  input wire logic [7:0] host_data_bus_i,
  output logic [7:0] host_data_bus_o,
  output logic host_data_bus_oe_o,
  output logic transfer_ack_n_o,
  output logic transfer_ack_n_oe_o,
  output logic host_interrupt_n_o,
  output logic host_interrupt_n_oe_o,
  // echo canceller core side
  input wire logic [3:0] channel_event_i,
  input wire logic [63:0] tx_sample_i,
  output logic [63:0] rx_sample_o,
  output logic rx_sample_valid_o,
  output logic standby_o,
  output logic mclk_10mhz_sel_o,
  // static pins
  input wire logic clock_freq_select_i,
  input wire logic output_drive_enable_i,
  // serial pcm link
  input wire logic serial_bit_clock_i,
  input wire logic frame_pulse_in_i,
  input wire logic receive_pcm_in_i,
  input wire logic send_pcm_in_i,
  output logic send_pcm_out_o,
  output logic send_pcm_out_oe_o,
  output logic receive_pcm_out_o,
  output logic receive_pcm_out_oe_o,
  // test access port
  input wire logic tck_i,
  input wire logic tms_i,
  input wire logic tdi_i,
  input wire logic trst_n_i,
  output logic tdo_o,
  output logic tdo_oe_o
);
  import echo_pin_pkg::*;

  host_regs_type st_reg;
  host_regs_type st_next;
  tap_regs_type tap_reg;
  tap_regs_type tap_next;
  logic tdo_reg;
  logic tdo_oe_reg;
  logic access;
  logic fifo_take;
  logic [`NUM_CH-1:0] clr_mask;
  logic [`DATA_W-1:0] rdata;
  logic [1:0] first_idx;

  tdm_link_if link_bus();

  // lowest pending channel is the head of the interrupt fifo
  function automatic logic [1:0] lowest_pending(input logic [`NUM_CH-1:0] p);
    logic [1:0] idx;
    idx = 2'h0;
    for (int i = `NUM_CH - 1; i >= 0; i--)
      if (p[i])
        idx = 2'(i);
    return idx;
  endfunction

  // ****************************************************************
  // host port, interrupt fifo, init and crossing control
  // ****************************************************************
  always_comb
  begin
    st_next = st_reg;
    // every host and static pin passes two flops before use; the master clock is unrelated to the pins
    st_next.cs_n_s1 = chip_select_n_i;
    st_next.cs_n_s2 = st_reg.cs_n_s1;
    st_next.ds_n_s1 = data_strobe_n_i;
    st_next.ds_n_s2 = st_reg.ds_n_s1;
    st_next.rw_s1 = read_write_dir_i;
    st_next.rw_s2 = st_reg.rw_s1;
    st_next.addr_s1 = host_address_bus_i;
    st_next.addr_s2 = st_reg.addr_s1;
    st_next.data_s1 = host_data_bus_i;
    st_next.data_s2 = st_reg.data_s1;
    st_next.ode_s1 = output_drive_enable_i;
    st_next.ode_s2 = st_reg.ode_s1;
    st_next.fsel_s1 = clock_freq_select_i;
    st_next.fsel_s2 = st_reg.fsel_s1;
    st_next.gci_s1 = link_bus.gci;
    st_next.gci_s2 = st_reg.gci_s1;
    st_next.rx_tog_s1 = link_bus.rx_tog;
    st_next.rx_tog_s2 = st_reg.rx_tog_s1;
    st_next.link_rst_n = 1'b1;
    st_next.rx_valid = 1'b0;

    // both strobes low qualify an access
    access = !st_reg.cs_n_s2 && !st_reg.ds_n_s2;
    first_idx = lowest_pending(st_reg.pending);
    fifo_take = 1'b0;
    clr_mask = '0;

    // register read mux; unmapped offsets read as zero
    case (st_reg.addr_s2)
      `REG_MAIN_CTRL: rdata = st_reg.main_ctrl;
      `REG_STATUS: rdata = {1'b0, st_reg.gci_s2, st_reg.fsel_s2, st_reg.ode_s2, st_reg.pending};
      `REG_INT_FIFO: rdata = (st_reg.pending != '0) ? {1'b1, 5'h00, first_idx} : 8'h00;
      default: rdata = 8'h00;
    endcase

    // initialisation runs by itself once reset is gone; no access until it ends
    if (st_reg.standby)
    begin
      if (st_reg.init_cnt == 8'(`INIT_CYCLES - 1))
        st_next.standby = 1'b0;
      else
        st_next.init_cnt = st_reg.init_cnt + 8'h01;
    end

    // access handshake
    case (st_reg.hs)
      HS_IDLE:
      begin
        if (access && !st_reg.standby)
        begin
          st_next.addr_s2 = st_reg.addr_s2;
          st_next.hs = HS_DRIVE;
          if (st_reg.rw_s2)
          begin
            // read: drive data a cycle ahead of the acknowledge
            st_next.data_out = rdata;
            st_next.data_oe = 1'b1;
            if ((st_reg.addr_s2 == `REG_INT_FIFO) && (st_reg.pending != '0))
            begin
              fifo_take = 1'b1;
              clr_mask[first_idx] = 1'b1;
            end
          end
          else if (st_reg.addr_s2 == `REG_MAIN_CTRL)
            st_next.main_ctrl = st_reg.data_s2;
        end
      end
      HS_DRIVE:
      begin
        st_next.ack_oe = 1'b1;
        st_next.hs = HS_ACK;
      end
      HS_ACK:
      begin
        if (!access)
        begin
          st_next.ack_oe = 1'b0;
          st_next.data_oe = 1'b0;
          st_next.hs = HS_IDLE;
        end
      end
      default:
      begin
        st_next.ack_oe = 1'b0;
        st_next.data_oe = 1'b0;
        st_next.hs = HS_IDLE;
      end
    endcase

    // a new event wins over a read that clears the same channel
    st_next.pending = (st_reg.pending & ~clr_mask) | channel_event_i;
    st_next.irq_oe = (st_reg.pending != '0);

    // serial outputs need the pin and the control bit together
    st_next.drive_en = st_reg.ode_s2 && st_reg.main_ctrl[`MAIN_CTRL_ODE_BIT];

    // a new received frame also triggers the next transmit frame hand-over
    if (st_reg.rx_tog_s2 != st_reg.rx_tog_seen)
    begin
      st_next.rx_tog_seen = st_reg.rx_tog_s2;
      st_next.rx_sample = link_bus.rx_word;
      st_next.rx_valid = 1'b1;
      st_next.tx_word = tx_sample_i;
      st_next.tx_tog = ~st_reg.tx_tog;
    end
  end

  // synchronous reset holds standby and all control at its defaults
  always_ff @(posedge sys_clk_i)
  begin
    if (!resetn_i)
    begin
      st_reg <= '0;
      st_reg.cs_n_s1 <= 1'b1;
      st_reg.cs_n_s2 <= 1'b1;
      st_reg.ds_n_s1 <= 1'b1;
      st_reg.ds_n_s2 <= 1'b1;
      st_reg.standby <= 1'b1;
      st_reg.main_ctrl <= `MAIN_CTRL_RESET;
      st_reg.hs <= HS_IDLE;
    end
    else
      st_reg <= st_next;
  end

  // open-drain pins only ever pull low
  assign host_data_bus_o = st_reg.data_out;
  assign host_data_bus_oe_o = st_reg.data_oe;
  assign transfer_ack_n_o = 1'b0;
  assign transfer_ack_n_oe_o = st_reg.ack_oe;
  assign host_interrupt_n_o = 1'b0;
  assign host_interrupt_n_oe_o = st_reg.irq_oe;
  assign rx_sample_o = st_reg.rx_sample;
  assign rx_sample_valid_o = st_reg.rx_valid;
  assign standby_o = st_reg.standby;
  assign mclk_10mhz_sel_o = st_reg.fsel_s2;
  assign link_bus.tx_word = st_reg.tx_word;
  assign link_bus.tx_tog = st_reg.tx_tog;
  assign link_bus.drive_en = st_reg.drive_en;
  assign link_bus.link_resetn = st_reg.link_rst_n;

  // serial port on its own bit clock
  tdm_serial_port u_link (
    .serial_bit_clock_i(serial_bit_clock_i),
    .frame_pulse_in_i(frame_pulse_in_i),
    .receive_pcm_in_i(receive_pcm_in_i),
    .send_pcm_in_i(send_pcm_in_i),
    .send_pcm_out_o(send_pcm_out_o),
    .send_pcm_out_oe_o(send_pcm_out_oe_o),
    .receive_pcm_out_o(receive_pcm_out_o),
    .receive_pcm_out_oe_o(receive_pcm_out_oe_o),
    .lb(link_bus.link)
  );

  // ****************************************************************
  // test access port
  // ****************************************************************
  always_comb
  begin
    tap_next = tap_reg;
    case (tap_reg.tap)
      TAP_RESET: tap_next.tap = tms_i ? TAP_RESET : TAP_IDLE;
      TAP_IDLE: tap_next.tap = tms_i ? TAP_SEL_DR : TAP_IDLE;
      TAP_SEL_DR: tap_next.tap = tms_i ? TAP_SEL_IR : TAP_CAP_DR;
      TAP_CAP_DR: tap_next.tap = tms_i ? TAP_EXIT1_DR : TAP_SHIFT_DR;
      TAP_SHIFT_DR: tap_next.tap = tms_i ? TAP_EXIT1_DR : TAP_SHIFT_DR;
      TAP_EXIT1_DR: tap_next.tap = tms_i ? TAP_UPD_DR : TAP_PAUSE_DR;
      TAP_PAUSE_DR: tap_next.tap = tms_i ? TAP_EXIT2_DR : TAP_PAUSE_DR;
      TAP_EXIT2_DR: tap_next.tap = tms_i ? TAP_UPD_DR : TAP_SHIFT_DR;
      TAP_UPD_DR: tap_next.tap = tms_i ? TAP_SEL_DR : TAP_IDLE;
      TAP_SEL_IR: tap_next.tap = tms_i ? TAP_RESET : TAP_CAP_IR;
      TAP_CAP_IR: tap_next.tap = tms_i ? TAP_EXIT1_IR : TAP_SHIFT_IR;
      TAP_SHIFT_IR: tap_next.tap = tms_i ? TAP_EXIT1_IR : TAP_SHIFT_IR;
      TAP_EXIT1_IR: tap_next.tap = tms_i ? TAP_UPD_IR : TAP_PAUSE_IR;
      TAP_PAUSE_IR: tap_next.tap = tms_i ? TAP_EXIT2_IR : TAP_PAUSE_IR;
      TAP_EXIT2_IR: tap_next.tap = tms_i ? TAP_UPD_IR : TAP_SHIFT_IR;
      TAP_UPD_IR: tap_next.tap = tms_i ? TAP_SEL_DR : TAP_IDLE;
      default: tap_next.tap = TAP_RESET;
    endcase
    // only bypass is implemented; every instruction selects it
    case (tap_reg.tap)
      TAP_RESET: tap_next.ir = `TAP_IR_BYPASS;
      TAP_CAP_IR: tap_next.ir_shift = `TAP_IR_CAPTURE;
      TAP_SHIFT_IR: tap_next.ir_shift = {tdi_i, tap_reg.ir_shift[`TAP_IR_W-1:1]};
      TAP_UPD_IR: tap_next.ir = tap_reg.ir_shift;
      TAP_CAP_DR: tap_next.bypass = 1'b0;
      TAP_SHIFT_DR: tap_next.bypass = tdi_i;
      default: tap_next.bypass = tap_reg.bypass;
    endcase
  end

  // test reset acts without waiting for a clock edge
  always_ff @(posedge tck_i or negedge trst_n_i)
  begin
    if (!trst_n_i)
    begin
      tap_reg.tap <= TAP_RESET;
      tap_reg.ir <= `TAP_IR_BYPASS;
      tap_reg.ir_shift <= '0;
      tap_reg.bypass <= 1'b0;
    end
    else
      tap_reg <= tap_next;
  end

  // data leaves on the falling edge so the far end samples it mid-cycle
  always_ff @(negedge tck_i or negedge trst_n_i)
  begin
    if (!trst_n_i)
    begin
      tdo_reg <= 1'b0;
      tdo_oe_reg <= 1'b0;
    end
    else
    begin
      tdo_reg <= (tap_reg.tap == TAP_SHIFT_IR) ? tap_reg.ir_shift[0] : tap_reg.bypass;
      tdo_oe_reg <= (tap_reg.tap == TAP_SHIFT_IR) || (tap_reg.tap == TAP_SHIFT_DR);
    end
  end

  assign tdo_o = tdo_reg;
  assign tdo_oe_o = tdo_oe_reg;

  // ****************************************************************
  // checks
  // ****************************************************************
  property p_irq_on_event;
    @(posedge sys_clk_i) disable iff (!resetn_i)
    (channel_event_i != '0) |-> ##[1:2] host_interrupt_n_oe_o;
  endproperty
  a_irq_on_event: assert property (p_irq_on_event) else $error("interrupt not raised on event");

  property p_irq_release;
    @(posedge sys_clk_i) disable iff (!resetn_i)
    $fell(host_interrupt_n_oe_o) |-> $past(fifo_take, 2) && (st_reg.pending == '0);
  endproperty
  a_irq_release: assert property (p_irq_release) else $error("interrupt released without fifo read");

  property p_access_qual;
    @(posedge sys_clk_i) disable iff (!resetn_i)
    (st_reg.hs == HS_IDLE) && !access |=> (st_reg.hs == HS_IDLE) && !host_data_bus_oe_o;
  endproperty
  a_access_qual: assert property (p_access_qual) else $error("access without select and strobe");

  property p_direction;
    @(posedge sys_clk_i) disable iff (!resetn_i)
    (st_reg.hs == HS_IDLE) && access && !st_reg.standby |=> (host_data_bus_oe_o == $past(st_reg.rw_s2));
  endproperty
  a_direction: assert property (p_direction) else $error("data bus direction wrong");

  sequence s_take;
    (st_reg.hs == HS_IDLE) && access && !st_reg.standby;
  endsequence
  sequence s_ack_seen;
    !transfer_ack_n_oe_o ##1 transfer_ack_n_oe_o;
  endsequence
  property p_ack;
    @(posedge sys_clk_i) disable iff (!resetn_i)
    s_take |=> s_ack_seen;
  endproperty
  a_ack: assert property (p_ack) else $error("acknowledge not given two cycles after take");

  property p_release;
    @(posedge sys_clk_i) disable iff (!resetn_i)
    (st_reg.hs == HS_ACK) && !access |=> !transfer_ack_n_oe_o && !host_data_bus_oe_o;
  endproperty
  a_release: assert property (p_release) else $error("ack or data held after strobe ended");

  property p_standby;
    @(posedge sys_clk_i)
    !resetn_i |=> standby_o && (st_reg.main_ctrl == `MAIN_CTRL_RESET);
  endproperty
  a_standby: assert property (p_standby) else $error("standby not held in reset");

  property p_init_done;
    @(posedge sys_clk_i) disable iff (!resetn_i)
    standby_o && (st_reg.init_cnt == 8'(`INIT_CYCLES - 1)) |=> !standby_o;
  endproperty
  a_init_done: assert property (p_init_done) else $error("initialisation did not finish");

  property p_tdo_hiz;
    @(negedge tck_i) disable iff (!trst_n_i)
    (tap_reg.tap == TAP_IDLE) |=> !tdo_oe_o;
  endproperty
  a_tdo_hiz: assert property (p_tdo_hiz) else $error("test data out driven outside scan");
endmodule

// ==== verification/tdm_backplane.sv ====
// tdm backplane model: bit clock, frame pulse and pcm input streams
`timescale 1ns/1ns
module tdm_backplane
(
  // pins towards the device
  output logic serial_bit_clock_o,
  output logic frame_pulse_o,
  output logic receive_pcm_o,
  output logic send_pcm_o
);
  int cnt = 0;
  // 64 ns bit clock, started off the system clock phase
  initial
  begin
    serial_bit_clock_o = 0;
    frame_pulse_o = 0;
    receive_pcm_o = 0;
    send_pcm_o = 1;
    #5;
    forever #32 serial_bit_clock_o = ~serial_bit_clock_o;
  end
  // one pulse per 512 link cycles, idle low; steady data over the slots, a moving pattern after them
  always @(negedge serial_bit_clock_o)
  begin
    cnt <= (cnt == 511) ? 0 : cnt + 1;
    frame_pulse_o <= (cnt == 511);
    receive_pcm_o <= (cnt < 80) ? 1'b1 : cnt[0];
    send_pcm_o <= (cnt < 80) ? 1'b0 : ~cnt[0];
  end
endmodule

// ==== verification/tb_top.sv ====
// self-checking bench of the echo canceller pin interface
`timescale 1ns/1ns
module tb_top;
  // trst_n held low from power-up keeps the test port in reset until its own scenario
  logic sys_clk_i = 0, resetn_i = 0, cs_n = 1, ds_n = 1, rw = 1, output_drive_enable = 0, trst_n = 0;
  logic tck = 0, tms = 1, tdi = 1;
  logic [10:0] addr = 0;
  logic [7:0] hd = 0, rd, dq;
  logic [3:0] ev = 0;
  logic [63:0] rxs;
  logic doe, aoe, ioe, rxv, sb, sck, fp, rin, sin, so, soe, ro, roe, toe, msel, tdo;
  int error_cnt = 0, checks = 0;
  // resolved data wire: device wins while it drives
  wire [7:0] bus = doe ? dq : hd;
  echo_canceller_pin_interface dut (.sys_clk_i, .resetn_i, .chip_select_n_i(cs_n), .data_strobe_n_i(ds_n),
    .read_write_dir_i(rw), .host_address_bus_i(addr), .host_data_bus_i(bus), .host_data_bus_o(dq),
    .host_data_bus_oe_o(doe), .transfer_ack_n_o(), .transfer_ack_n_oe_o(aoe), .host_interrupt_n_o(),
    .host_interrupt_n_oe_o(ioe), .channel_event_i(ev), .tx_sample_i({32'hffff_ffff, 32'h0000_0000}),
    .rx_sample_o(rxs), .rx_sample_valid_o(rxv), .standby_o(sb), .mclk_10mhz_sel_o(msel), .clock_freq_select_i(1'b0),
    .output_drive_enable_i(output_drive_enable), .serial_bit_clock_i(sck), .frame_pulse_in_i(fp), .receive_pcm_in_i(rin),
    .send_pcm_in_i(sin), .send_pcm_out_o(so), .send_pcm_out_oe_o(soe), .receive_pcm_out_o(ro),
    .receive_pcm_out_oe_o(roe), .tck_i(tck), .tms_i(tms), .tdi_i(tdi), .trst_n_i(trst_n), .tdo_o(tdo),
    .tdo_oe_o(toe));
  tdm_backplane far (.serial_bit_clock_o(sck), .frame_pulse_o(fp), .receive_pcm_o(rin), .send_pcm_o(sin));
  always #4 sys_clk_i = ~sys_clk_i;
  task chk(input logic [63:0] s, e);
    checks++;
    if (s !== e)
    begin
      error_cnt++;
      $display("MISMATCH %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task results;
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // bounded wait on the acknowledge level; running out ends the run
  task wt(input logic lvl);
    int i;
    for (i = 0; i < 40 && aoe !== lvl; i++)
      @(posedge sys_clk_i);
    if (aoe !== lvl)
    begin
      error_cnt++;
      results;
    end
  endtask
  // one host access: hold everything until ack, then release and wait for ack to drop
  task acc(input logic r, input logic [10:0] a, input logic [7:0] w);
    @(posedge sys_clk_i);
    cs_n <= 0;
    ds_n <= 0;
    rw <= r;
    addr <= a;
    hd <= w;
    wt(1);
    rd = dq;
    cs_n <= 1;
    ds_n <= 1;
    hd <= ~w;
    wt(0);
  endtask
  task t_reset;
    chk({toe, doe, aoe, ioe, sb}, 5'h01);
    resetn_i <= 1;
    repeat (118) @(posedge sys_clk_i);
    chk(sb, 1);
    // the link side clears a few bit clocks after release, so its enables are looked at here
    chk({soe, roe}, 2'b00);
    repeat (14) @(posedge sys_clk_i);
    chk(sb, 0);
    chk(msel, 0);
    acc(1, 11'h000, 8'h00);
    chk(rd, 8'h00);
    $display("reset test done");
  endtask
  task t_irq;
    @(posedge sys_clk_i);
    ev <= 4'h4;
    @(posedge sys_clk_i);
    ev <= 4'h0;
    repeat (3) @(posedge sys_clk_i);
    chk(ioe, 1);
    acc(1, 11'h002, 8'h00);
    chk(rd, 8'h82);
    repeat (3) @(posedge sys_clk_i);
    chk(ioe, 0);
    $display("interrupt test done");
  endtask
  task t_link;
    int i, n, k, m;
    acc(0, 11'h000, 8'h40);
    acc(1, 11'h000, 8'h00);
    chk(rd, 8'h40);
    n = 0;
    k = 0;
    // pin low: outputs stay released over two frames while input frames arrive
    for (i = 0; i < 9000; i++)
    begin
      @(posedge sys_clk_i);
      if (soe !== 0 || roe !== 0)
        n++;
      if (rxv === 1)
        k++;
      if (rxv === 1)
        chk(rxs, {32'hffff_ffff, 32'h0000_0000});
    end
    chk(n, 0);
    chk(k > 0, 1);
    output_drive_enable <= 1;
    n = 0;
    m = 0;
    // 32 bits of two link cycles each, 8 system cycles per link cycle
    for (i = 0; i < 9000; i++)
    begin
      @(posedge sys_clk_i);
      if (soe === 1 && roe === 1)
        n++;
      // all-ones send stream and all-zeros receive stream while the slots are driven
      if (soe === 1 && (so !== 1 || ro !== 0))
        m++;
    end
    chk(n >= 500 && n <= 1560, 1);
    chk(m, 0);
    acc(1, 11'h001, 8'h00);
    chk(rd, 8'h50);
    $display("link test done");
  endtask
  // one test clock: tms and tdi move while tck is low, then tck rises and falls
  task tk(input logic m, d);
    @(posedge sys_clk_i);
    tms <= m;
    tdi <= d;
    @(posedge sys_clk_i);
    tck <= 1;
    @(posedge sys_clk_i);
    tck <= 0;
  endtask
  task t_tap;
    @(posedge sys_clk_i);
    trst_n <= 1;
    tk(0, 0);
    tk(1, 0);
    tk(0, 0);
    tk(0, 0);
    @(posedge sys_clk_i);
    chk({toe, tdo}, 2'b10);
    tk(0, 1);
    @(posedge sys_clk_i);
    chk({toe, tdo}, 2'b11);
    trst_n <= 0;
    @(posedge sys_clk_i);
    chk(toe, 0);
    $display("test port test done");
  endtask
  initial
  begin
    repeat (16) @(posedge sys_clk_i);
    t_reset;
    t_irq;
    t_link;
    t_tap;
    results;
  end
endmodule
